// ==== core/sfr_reset_defines.svh ====
`ifndef SFR_RESET_DEFINES_SVH
`define SFR_RESET_DEFINES_SVH

// ***************************************************************
// bank select codes
// ***************************************************************
`define BANK_1 2'h1
`define BANK_2 2'h2
`define BANK_3 2'h3

// ***************************************************************
// register offsets (address = {bank, offset})
// ***************************************************************
`define OFS_P8_DIR   6'h08
`define OFS_B1_RSVD  6'h09
`define OFS_CMP_CTL  6'h0a
`define OFS_PD_DIS   6'h0b
`define OFS_OD_DIS   6'h0c
`define OFS_PH_DIS   6'h0d
`define OFS_WDT_CTL  6'h0e
`define OFS_IRQ_MASK 6'h0f
`define OFS_P6_HD    6'h05
`define OFS_P5_HS    6'h06
`define OFS_P6_HS    6'h07
`define OFS_OP_MODE  6'h08
`define OFS_B2_RSVD  6'h09
`define OFS_B2_LAST  6'h0f
`define OFS_TMR_CNT  6'h05
`define OFS_OSC_CAL  6'h06
`define OFS_RST_OPT  6'h07
`define OFS_GP_BASE  6'h10
`define OFS_BK_BASE  6'h20
`define OFS_BK_LAST  6'h3f

// ***************************************************************
// reset values and reset masks (mask bit 1 = loaded by reset)
// ***************************************************************
`define RST_P8_DIR   8'h03
`define RST_ZERO     8'h00
`define RST_ONES     8'hff
`define RST_OP_MODE  8'h70
`define MSK_OP_MODE  8'h70
`define RST_OSC_CAL  8'hfc
`define MSK_OSC_CAL  8'hfc
`define RST_RST_OPT  8'h0f
`define MSK_RST_OPT  8'h0f

// ***************************************************************
// field positions
// ***************************************************************
`define CMP_RESULT_BIT 5
`define WDT_EN_BIT     7

`endif

// ==== core/sfr_reset_pkg.sv ====
package sfr_reset_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [5:0] ofs_t;
   typedef logic [1:0] bank_t;
   typedef enum logic [1:0] {RST_NONE, RST_POWER, RST_PIN_WDT} reset_kind_e;
endpackage

// ==== core/reset_source.sv ====
`include "sfr_reset_defines.svh"

module reset_source (
   // clock and power-on reset
   input  wire logic                       mclk_i,
   input  wire logic                       rst_n_i,
   // raw sources
   input  wire logic                       ext_reset_n_i,
   input  wire logic                       wdt_timeout_i,
   input  wire logic                       wdt_enable_i,
   // result
   output      sfr_reset_pkg::reset_kind_e kind_o
);
   import sfr_reset_pkg::*;

   logic       pin_s1_r;
   logic       pin_s2_r;
   logic       wdt_s1_r;
   logic       wdt_s2_r;

   // ***************************************************************
   // synchronisers
   // ***************************************************************
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
         wdt_s1_r <= 1'b0;
         wdt_s2_r <= 1'b0;
      end else begin
         pin_s1_r <= ext_reset_n_i;
         pin_s2_r <= pin_s1_r;
         wdt_s1_r <= wdt_timeout_i;
         wdt_s2_r <= wdt_s1_r;
      end
   end

   // ***************************************************************
   // classification
   // ***************************************************************
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         kind_o <= RST_POWER;
      end else if (!pin_s2_r || (wdt_s2_r && wdt_enable_i)) begin
         kind_o <= RST_PIN_WDT;
      end else begin
         kind_o <= RST_NONE;
      end
   end
endmodule // reset_source

// ==== core/general_storage.sv ====
`include "sfr_reset_defines.svh"

module general_storage #(
   parameter int DEPTH = 48
) (
   // clock
   input  wire logic                  mclk_i,
   // access
   input  wire logic [5:0]            idx_i,
   input  wire logic                  wr_i,
   input  wire logic [7:0]            wdata_i,
   output      logic [7:0]            rdata_o
);
   logic [7:0] mem [DEPTH];

   // ***************************************************************
   // storage, no reset: contents kept across every reset
   // ***************************************************************
   always_ff @(posedge mclk_i) begin
      if (wr_i && (int'(idx_i) < DEPTH)) begin
         mem[idx_i] <= wdata_i;
      end
   end

   // read is combinational; the caller registers it on its read data port
   assign rdata_o = (int'(idx_i) < DEPTH) ? mem[idx_i] : 8'h00;
endmodule // general_storage

// ==== core/sfr_reset_bank.sv ====
`include "sfr_reset_defines.svh"

module sfr_reset_bank #(
   parameter int GP_DEPTH = 48
) (
   // clock and reset
   input  wire logic                  mclk_i,
   input  wire logic                  rst_n_i,
   // reset sources and wake-up input
   input  wire logic                  ext_reset_n_i,
   input  wire logic                  wdt_timeout_i,
   input  wire logic                  pin_wakeup_i,
   // comparator status
   input  wire logic                  comparator_result_i,
   // timer
   input  wire logic                  timer_tick_i,
   // register port
   input  wire sfr_reset_pkg::bank_t  bank_i,
   input  wire sfr_reset_pkg::ofs_t   addr_i,
   input  wire sfr_reset_pkg::byte_t  wdata_i,
   input  wire logic                  wr_i,
   input  wire logic                  rd_i,
   output      sfr_reset_pkg::byte_t  rdata_o,
   // control outputs
   output      sfr_reset_pkg::byte_t  port8_direction_o,
   output      sfr_reset_pkg::byte_t  comparator_control_o,
   output      sfr_reset_pkg::byte_t  pull_down_disable_n_o,
   output      sfr_reset_pkg::byte_t  open_drain_disable_n_o,
   output      sfr_reset_pkg::byte_t  pull_high_disable_n_o,
   output      sfr_reset_pkg::byte_t  watchdog_control_o,
   output      sfr_reset_pkg::byte_t  interrupt_mask_o,
   output      sfr_reset_pkg::byte_t  port6_high_drive_o,
   output      sfr_reset_pkg::byte_t  port5_high_sink_o,
   output      sfr_reset_pkg::byte_t  port6_high_sink_o,
   output      sfr_reset_pkg::byte_t  operating_mode_control_o,
   output      sfr_reset_pkg::byte_t  timer_count_o,
   output      sfr_reset_pkg::byte_t  oscillator_calibration_o,
   output      sfr_reset_pkg::byte_t  reset_noise_options_o,
   output      logic                  sync_reset_o
);
   import sfr_reset_pkg::*;

   reset_kind_e kind;
   logic        rst_pw;
   logic        wake_s1_r;
   logic        wake_s2_r;
   logic        wake_hold;
   logic        cmp_s1_r;
   logic        cmp_s2_r;
   logic        tick_s1_r;
   logic        tick_s2_r;
   logic        tick_s3_r;
   logic        gp_sel;
   logic        sel_b1;
   logic        sel_b2;
   logic        sel_b3;
   byte_t       gp_rdata;
   byte_t       rd_nxt;
   ofs_t        gp_idx;

   // ***************************************************************
   // reset source and input synchronisers
   // ***************************************************************
   reset_source u_src (
      .mclk_i        (mclk_i),
      .rst_n_i       (rst_n_i),
      .ext_reset_n_i (ext_reset_n_i),
      .wdt_timeout_i (wdt_timeout_i),
      .wdt_enable_i  (watchdog_control_o[`WDT_EN_BIT]),
      .kind_o        (kind)
   );

   assign rst_pw = (kind == RST_PIN_WDT);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_s1_r <= 1'b0;
         wake_s2_r <= 1'b0;
         cmp_s1_r  <= 1'b0;
         cmp_s2_r  <= 1'b0;
         tick_s1_r <= 1'b0;
         tick_s2_r <= 1'b0;
         tick_s3_r <= 1'b0;
      end else begin
         wake_s1_r <= pin_wakeup_i;
         wake_s2_r <= wake_s1_r;
         cmp_s1_r  <= comparator_result_i;
         cmp_s2_r  <= cmp_s1_r;
         tick_s1_r <= timer_tick_i;
         tick_s2_r <= tick_s1_r;
         tick_s3_r <= tick_s2_r;
      end
   end

   // wake-up freezes software writes and timer while the synchronised wake-up input is high
   assign wake_hold = wake_s2_r;

   assign sel_b1 = (bank_i == `BANK_1) && wr_i && !rst_pw && !wake_hold;
   assign sel_b2 = (bank_i == `BANK_2) && wr_i && !rst_pw && !wake_hold;
   assign sel_b3 = (bank_i == `BANK_3) && wr_i && !rst_pw && !wake_hold;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_reset_o <= 1'b1;
      end else begin
         sync_reset_o <= rst_pw;
      end
   end

   // ***************************************************************
   // bank 1 registers
   // ***************************************************************
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         port8_direction_o <= `RST_P8_DIR;
      end else if (rst_pw) begin
         port8_direction_o <= `RST_P8_DIR;
      end else if (sel_b1 && addr_i == `OFS_P8_DIR) begin
         port8_direction_o <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         comparator_control_o <= `RST_ZERO;
      end else if (rst_pw) begin
         comparator_control_o <= `RST_ZERO;
      end else if (wake_hold) begin
         comparator_control_o <= comparator_control_o;
      end else begin
         if (sel_b1 && addr_i == `OFS_CMP_CTL) begin
            comparator_control_o <= wdata_i;
         end
         comparator_control_o[`CMP_RESULT_BIT] <= cmp_s2_r;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pull_down_disable_n_o <= `RST_ONES;
      end else if (rst_pw) begin
         pull_down_disable_n_o <= `RST_ONES;
      end else if (sel_b1 && addr_i == `OFS_PD_DIS) begin
         pull_down_disable_n_o <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         open_drain_disable_n_o <= `RST_ONES;
      end else if (rst_pw) begin
         open_drain_disable_n_o <= `RST_ONES;
      end else if (sel_b1 && addr_i == `OFS_OD_DIS) begin
         open_drain_disable_n_o <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pull_high_disable_n_o <= `RST_ONES;
      end else if (rst_pw) begin
         pull_high_disable_n_o <= `RST_ONES;
      end else if (sel_b1 && addr_i == `OFS_PH_DIS) begin
         pull_high_disable_n_o <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         watchdog_control_o <= `RST_ZERO;
      end else if (rst_pw) begin
         watchdog_control_o <= `RST_ZERO;
      end else if (sel_b1 && addr_i == `OFS_WDT_CTL) begin
         watchdog_control_o <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         interrupt_mask_o <= `RST_ZERO;
      end else if (rst_pw) begin
         interrupt_mask_o <= `RST_ZERO;
      end else if (sel_b1 && addr_i == `OFS_IRQ_MASK) begin
         interrupt_mask_o <= wdata_i;
      end
   end

   // ***************************************************************
   // bank 2 registers
   // ***************************************************************
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         port6_high_drive_o <= `RST_ZERO;
      end else if (rst_pw) begin
         port6_high_drive_o <= `RST_ZERO;
      end else if (sel_b2 && addr_i == `OFS_P6_HD) begin
         port6_high_drive_o <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         port5_high_sink_o <= `RST_ZERO;
      end else if (rst_pw) begin
         port5_high_sink_o <= `RST_ZERO;
      end else if (sel_b2 && addr_i == `OFS_P5_HS) begin
         port5_high_sink_o <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         port6_high_sink_o <= `RST_ZERO;
      end else if (rst_pw) begin
         port6_high_sink_o <= `RST_ZERO;
      end else if (sel_b2 && addr_i == `OFS_P6_HS) begin
         port6_high_sink_o <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         operating_mode_control_o <= `RST_OP_MODE;
      end else if (rst_pw) begin
         operating_mode_control_o <= operating_mode_control_o | `MSK_OP_MODE;
      end else if (sel_b2 && addr_i == `OFS_OP_MODE) begin
         operating_mode_control_o <= wdata_i;
      end
   end

   // ***************************************************************
   // bank 3 registers
   // ***************************************************************
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_count_o <= `RST_ZERO;
      end else if (rst_pw) begin
         timer_count_o <= `RST_ZERO;
      end else if (sel_b3 && addr_i == `OFS_TMR_CNT) begin
         timer_count_o <= wdata_i;
      end else if (tick_s2_r && !tick_s3_r && !wake_hold) begin
         timer_count_o <= timer_count_o + 8'h01;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         oscillator_calibration_o <= `RST_OSC_CAL;
      end else if (rst_pw) begin
         oscillator_calibration_o <= oscillator_calibration_o | `MSK_OSC_CAL;
      end else if (sel_b3 && addr_i == `OFS_OSC_CAL) begin
         oscillator_calibration_o <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reset_noise_options_o <= `RST_RST_OPT;
      end else if (rst_pw) begin
         reset_noise_options_o <= reset_noise_options_o | `MSK_RST_OPT;
      end else if (sel_b3 && addr_i == `OFS_RST_OPT) begin
         reset_noise_options_o <= wdata_i;
      end
   end

   // ***************************************************************
   // general storage, shared by all banks
   // ***************************************************************
   assign gp_sel = (addr_i >= `OFS_GP_BASE);
   assign gp_idx = addr_i - `OFS_GP_BASE;

   general_storage #(
      .DEPTH (GP_DEPTH)
   ) u_gp (
      .mclk_i  (mclk_i),
      .idx_i   (gp_idx),
      .wr_i    (wr_i && gp_sel && !wake_hold && !rst_pw),
      .wdata_i (wdata_i),
      .rdata_o (gp_rdata)
   );

   // ***************************************************************
   // read path
   // ***************************************************************
   always_comb begin
      rd_nxt = 8'h00;
      unique case (bank_i)
         `BANK_1: begin
            case (addr_i)
               `OFS_P8_DIR:   rd_nxt = port8_direction_o;
               `OFS_CMP_CTL:  rd_nxt = comparator_control_o;
               `OFS_PD_DIS:   rd_nxt = pull_down_disable_n_o;
               `OFS_OD_DIS:   rd_nxt = open_drain_disable_n_o;
               `OFS_PH_DIS:   rd_nxt = pull_high_disable_n_o;
               `OFS_WDT_CTL:  rd_nxt = watchdog_control_o;
               `OFS_IRQ_MASK: rd_nxt = interrupt_mask_o;
               default:       rd_nxt = 8'h00;
            endcase
         end
         `BANK_2: begin
            case (addr_i)
               `OFS_P6_HD:   rd_nxt = port6_high_drive_o;
               `OFS_P5_HS:   rd_nxt = port5_high_sink_o;
               `OFS_P6_HS:   rd_nxt = port6_high_sink_o;
               `OFS_OP_MODE: rd_nxt = operating_mode_control_o;
               default:      rd_nxt = 8'h00;
            endcase
         end
         `BANK_3: begin
            case (addr_i)
               `OFS_TMR_CNT: rd_nxt = timer_count_o;
               `OFS_OSC_CAL: rd_nxt = oscillator_calibration_o;
               `OFS_RST_OPT: rd_nxt = reset_noise_options_o;
               default:      rd_nxt = 8'h00;
            endcase
         end
         default: rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i && !gp_sel) begin
         rdata_o <= rd_nxt;
      end else if (rd_i) begin
         rdata_o <= gp_rdata;
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule // sfr_reset_bank

// ==== testbench/sfr_reset_bank_asserts.sv ====
`include "sfr_reset_defines.svh"

module sfr_reset_bank_asserts
   import sfr_reset_pkg::*;
#(
   parameter int GP_DEPTH = 48
) (
   // clock, reset and sources
   input wire logic                  mclk_i,
   input wire logic                  rst_n_i,
   input wire logic                  ext_reset_n_i,
   input wire logic                  wdt_timeout_i,
   input wire logic                  pin_wakeup_i,
   // register port
   input wire sfr_reset_pkg::bank_t  bank_i,
   input wire sfr_reset_pkg::ofs_t   addr_i,
   input wire sfr_reset_pkg::byte_t  wdata_i,
   input wire logic                  wr_i,
   input wire logic                  rd_i,
   input wire sfr_reset_pkg::byte_t  rdata_o,
   // register copies
   input wire sfr_reset_pkg::byte_t  port8_direction_o,
   input wire sfr_reset_pkg::byte_t  comparator_control_o,
   input wire sfr_reset_pkg::byte_t  pull_down_disable_n_o,
   input wire sfr_reset_pkg::byte_t  open_drain_disable_n_o,
   input wire sfr_reset_pkg::byte_t  pull_high_disable_n_o,
   input wire sfr_reset_pkg::byte_t  watchdog_control_o,
   input wire sfr_reset_pkg::byte_t  interrupt_mask_o,
   input wire sfr_reset_pkg::byte_t  port6_high_drive_o,
   input wire sfr_reset_pkg::byte_t  port5_high_sink_o,
   input wire sfr_reset_pkg::byte_t  port6_high_sink_o,
   input wire sfr_reset_pkg::byte_t  operating_mode_control_o,
   input wire sfr_reset_pkg::byte_t  timer_count_o,
   input wire sfr_reset_pkg::byte_t  oscillator_calibration_o,
   input wire sfr_reset_pkg::byte_t  reset_noise_options_o,
   input wire logic                  sync_reset_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   // ***************************************************************
   // sequences
   // ***************************************************************
   sequence quiet_s;
      (!pin_wakeup_i && ext_reset_n_i && !wdt_timeout_i && !sync_reset_o) [*4];
   endsequence
   sequence frozen_s;
      (pin_wakeup_i && ext_reset_n_i && !sync_reset_o) [*4];
   endsequence
   property p8_write_p;
      byte_t d;
      (quiet_s ##0 (wr_i && bank_i == `BANK_1 && addr_i == `OFS_P8_DIR, d = wdata_i))
         |-> ##[1:2] port8_direction_o == d;
   endproperty

   // ***************************************************************
   // assertions
   // ***************************************************************
   ones_reset_a : assert property ($fell(sync_reset_o) |-> port8_direction_o == 8'h03
      && pull_down_disable_n_o == 8'hff && open_drain_disable_n_o == 8'hff
      && pull_high_disable_n_o == 8'hff) else $error("set-type reset value wrong");
   zero_reset_a : assert property ($fell(sync_reset_o) |-> watchdog_control_o == 8'h00
      && interrupt_mask_o == 8'h00 && port6_high_drive_o == 8'h00
      && port5_high_sink_o == 8'h00 && port6_high_sink_o == 8'h00
      && timer_count_o == 8'h00 && (comparator_control_o & 8'hdf) == 8'h00)
      else $error("clear-type reset value wrong");
   masked_reset_a : assert property ($fell(sync_reset_o) |->
      (operating_mode_control_o & 8'h70) == 8'h70 && (oscillator_calibration_o & 8'hfc) == 8'hfc
      && (reset_noise_options_o & 8'h0f) == 8'h0f) else $error("masked reset bits wrong");
   reserved_read_a : assert property (rd_i && ((bank_i == `BANK_1 && addr_i == `OFS_B1_RSVD)
      || (bank_i == `BANK_2 && addr_i >= `OFS_B2_RSVD && addr_i <= `OFS_B2_LAST)) |=> rdata_o == 8'h00)
      else $error("reserved location read nonzero");
   read_idle_a : assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data without read");
   reg_write_a : assert property (p8_write_p) else $error("write not taken");
   wakeup_hold_a : assert property (frozen_s |-> $stable(port8_direction_o)
      && $stable(timer_count_o) && $stable(watchdog_control_o)
      && $stable(operating_mode_control_o)) else $error("register changed in wake-up");
   pin_reset_a : assert property ($fell(ext_reset_n_i) |-> ##[1:5] sync_reset_o)
      else $error("pin reset not seen");
   wdt_reset_a : assert property ($rose(wdt_timeout_i) && watchdog_control_o[7]
      |-> ##[1:5] sync_reset_o) else $error("watchdog reset not seen");
   wdt_gate_a : assert property ((wdt_timeout_i && !watchdog_control_o[7] && ext_reset_n_i) [*6]
      |-> !sync_reset_o) else $error("disabled watchdog caused reset");
endmodule // sfr_reset_bank_asserts

// ==== testbench/sfr_reset_bank_tb.sv ====
`include "sfr_reset_defines.svh"

module sfr_reset_bank_tb;
   import sfr_reset_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {bank_t b; ofs_t o; byte_t rst; byte_t msk; byte_t wm;} row_s;

   logic  mclk_i = 1'b0;
   logic  rst_n_i = 1'b0;
   logic  ext_reset_n_i = 1'b1;
   logic  wdt_timeout_i = 1'b0;
   logic  pin_wakeup_i = 1'b0;
   logic  comparator_result_i = 1'b0;
   logic  timer_tick_i = 1'b0;
   bank_t bank_i = 2'h0;
   ofs_t  addr_i = 6'h00;
   byte_t wdata_i = 8'h00;
   logic  wr_i = 1'b0;
   logic  rd_i = 1'b0;
   byte_t rdata_o, p8_o, cmp_o, pd_o, od_o, ph_o, wdt_o, msk_o;
   byte_t hd_o, hs5_o, hs6_o, op_o, tmr_o, osc_o, opt_o;
   logic  sync_reset_o;
   int    checked = 0;
   int    n_mismatch = 0;
   byte_t q;

   // bank, offset, reset value, bits loaded by reset, writable bits
   row_s rows [20] = '{
      '{`BANK_1, `OFS_P8_DIR,   8'h03, 8'hff, 8'hff},
      '{`BANK_1, `OFS_B1_RSVD,  8'h00, 8'hff, 8'h00},
      '{`BANK_1, `OFS_CMP_CTL,  8'h00, 8'hff, 8'hdf},
      '{`BANK_1, `OFS_PD_DIS,   8'hff, 8'hff, 8'hff},
      '{`BANK_1, `OFS_OD_DIS,   8'hff, 8'hff, 8'hff},
      '{`BANK_1, `OFS_PH_DIS,   8'hff, 8'hff, 8'hff},
      '{`BANK_1, `OFS_WDT_CTL,  8'h00, 8'hff, 8'hff},
      '{`BANK_1, `OFS_IRQ_MASK, 8'h00, 8'hff, 8'hff},
      '{`BANK_2, `OFS_P6_HD,    8'h00, 8'hff, 8'hff},
      '{`BANK_2, `OFS_P5_HS,    8'h00, 8'hff, 8'hff},
      '{`BANK_2, `OFS_P6_HS,    8'h00, 8'hff, 8'hff},
      '{`BANK_2, `OFS_OP_MODE,  8'h70, 8'h70, 8'hff},
      '{`BANK_2, `OFS_B2_RSVD,  8'h00, 8'hff, 8'h00},
      '{`BANK_2, `OFS_B2_LAST,  8'h00, 8'hff, 8'h00},
      '{`BANK_3, `OFS_TMR_CNT,  8'h00, 8'hff, 8'hff},
      '{`BANK_3, `OFS_OSC_CAL,  8'hfc, 8'hfc, 8'hff},
      '{`BANK_3, `OFS_RST_OPT,  8'h0f, 8'h0f, 8'hff},
      '{`BANK_1, `OFS_GP_BASE,  8'h00, 8'h00, 8'hff},
      '{`BANK_2, `OFS_BK_LAST,  8'h00, 8'h00, 8'hff},
      '{2'h0,    `OFS_CMP_CTL,  8'h00, 8'hff, 8'h00}
   };

   always #25 mclk_i = ~mclk_i;

   sfr_reset_bank #(.GP_DEPTH(48)) uut (
      .mclk_i, .rst_n_i, .ext_reset_n_i, .wdt_timeout_i, .pin_wakeup_i,
      .comparator_result_i, .timer_tick_i, .bank_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .port8_direction_o(p8_o), .comparator_control_o(cmp_o),
      .pull_down_disable_n_o(pd_o), .open_drain_disable_n_o(od_o),
      .pull_high_disable_n_o(ph_o), .watchdog_control_o(wdt_o), .interrupt_mask_o(msk_o),
      .port6_high_drive_o(hd_o), .port5_high_sink_o(hs5_o), .port6_high_sink_o(hs6_o),
      .operating_mode_control_o(op_o), .timer_count_o(tmr_o),
      .oscillator_calibration_o(osc_o), .reset_noise_options_o(opt_o), .sync_reset_o);

   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic chk(input byte_t seen, input byte_t exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input bank_t b, input ofs_t o, input byte_t d);
      @(posedge mclk_i);
      bank_i  <= b;
      addr_i  <= o;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input bank_t b, input ofs_t o, output byte_t d);
      @(posedge mclk_i);
      bank_i <= b;
      addr_i <= o;
      rd_i   <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic wait_sync(input logic v);
      int n;
      n = 0;
      while (sync_reset_o !== v && n < 30) begin
         @(posedge mclk_i);
         n++;
      end
      chk({7'h0, sync_reset_o}, {7'h0, v});
   endtask

   task automatic wrap_up();
      $display("checked %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      foreach (rows[i]) begin
         rd(rows[i].b, rows[i].o, q);
         chk(q & rows[i].msk, rows[i].rst & rows[i].msk);
      end
      foreach (rows[i]) wr(rows[i].b, rows[i].o, 8'ha5);
      foreach (rows[i]) begin
         rd(rows[i].b, rows[i].o, q);
         chk(q, 8'ha5 & rows[i].wm);
      end
      pin_wakeup_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      wr(`BANK_1, `OFS_P8_DIR, 8'h3c);
      rd(`BANK_1, `OFS_P8_DIR, q);
      chk(q, 8'ha5);
      pin_wakeup_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      ext_reset_n_i <= 1'b0;
      repeat (6) @(posedge mclk_i);
      chk({7'h0, sync_reset_o}, 8'h01);
      ext_reset_n_i <= 1'b1;
      wait_sync(1'b0);
      foreach (rows[i]) begin
         rd(rows[i].b, rows[i].o, q);
         chk(q, (8'ha5 & rows[i].wm & ~rows[i].msk) | (rows[i].rst & rows[i].msk));
      end
      wr(`BANK_1, `OFS_P8_DIR, 8'h3c);
      wdt_timeout_i <= 1'b1;
      repeat (8) @(posedge mclk_i);
      chk({7'h0, sync_reset_o}, 8'h00);
      wdt_timeout_i <= 1'b0;
      wr(`BANK_1, `OFS_WDT_CTL, 8'h80);
      repeat (3) @(posedge mclk_i);
      wdt_timeout_i <= 1'b1;
      wait_sync(1'b1);
      wdt_timeout_i <= 1'b0;
      wait_sync(1'b0);
      rd(`BANK_1, `OFS_P8_DIR, q);
      chk(q, 8'h03);
      rd(`BANK_1, `OFS_WDT_CTL, q);
      chk(q, 8'h00);
      wr(`BANK_3, `OFS_TMR_CNT, 8'hfe);
      repeat (3) begin
         timer_tick_i <= 1'b1;
         repeat (4) @(posedge mclk_i);
         timer_tick_i <= 1'b0;
         repeat (4) @(posedge mclk_i);
      end
      chk(tmr_o, 8'h01);
      comparator_result_i <= 1'b1;
      repeat (5) @(posedge mclk_i);
      rd(`BANK_1, `OFS_CMP_CTL, q);
      chk(q & 8'h20, 8'h20);
      comparator_result_i <= 1'b0;
      wr(`BANK_1, `OFS_PH_DIS, 8'h00);
      rst_n_i <= 1'b0;
      @(posedge mclk_i);
      #1 chk(ph_o, 8'hff);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      wrap_up();
   end

   initial begin
      #100us;
      n_mismatch++;
      wrap_up();
   end
endmodule // sfr_reset_bank_tb

bind sfr_reset_bank sfr_reset_bank_asserts #(.GP_DEPTH(GP_DEPTH)) u_chk (
   .mclk_i, .rst_n_i, .ext_reset_n_i, .wdt_timeout_i, .pin_wakeup_i, .bank_i, .addr_i,
   .wdata_i, .wr_i, .rd_i, .rdata_o, .port8_direction_o, .comparator_control_o,
   .pull_down_disable_n_o, .open_drain_disable_n_o, .pull_high_disable_n_o,
   .watchdog_control_o, .interrupt_mask_o, .port6_high_drive_o, .port5_high_sink_o,
   .port6_high_sink_o, .operating_mode_control_o, .timer_count_o,
   .oscillator_calibration_o, .reset_noise_options_o, .sync_reset_o);
